// File: design/apb_unit.sv
// Subscriber buffer unit: stores terminal characters, answers polls.
// Assumes the terminal strobe comes from logic on sys_clk_i.
//
// Summary of operation
// RL1: Low-speed poll reply sends up to 8 characters
// RL2: Set request bit when fill reaches threshold
// RL3: Threshold sits at 96 stored characters
// RL4: Request bit sent only in low-speed reply
// RL5: Clear request bit when fill drops below threshold
// RL6: Terminal characters accepted at all times; code drops them while the buffer is full or clk_en_i is low
// RL7: Answer each high-speed poll with buffered data
// RL8: Controller stops high-speed polls without request
// RL9: Buffer holds at least 192 characters
// RL10: Terminal characters carry 7 information bits
// RL11: Controller low-speed polls about ten per second
// RL12: High-speed units get 19.2 kb/s line rate
// RL13: Thirty-two polls between two low-speed polls
// RL14: Reply request bit reflects fill at poll
`timescale 1ns/1ns
module apbuf_unit
   import apbuf_pkg::*;
#(
   parameter int DEPTH = APBUF_DEPTH,
   parameter int THRESH = APBUF_THRESH,
   parameter int BURST = APBUF_LS_CHARS
) (
   // Clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic clk_en_i,
   // Terminal side
   input wire logic [APBUF_CHAR_W-1:0] term_char_i,
   input wire logic term_valid_i,
   output logic term_drop_o,
   output logic hs_req_o,
   output logic [APBUF_CNT_W-1:0] fill_o,
   // Poll link
   apbuf_link_if.unit_mp link
);
   // ==========================================================
   // Storage
   typedef enum logic [1:0] {
      APBUF_U_IDLE = 2'b00,
      APBUF_U_SEND = 2'b01,
      APBUF_U_DONE = 2'b10
   } apbuf_ustate_t;

   // Character store; sized for two low-speed intervals of input
   logic [APBUF_CHAR_W-1:0] mem_q [DEPTH]; // RL9
   // Store pointers, fill count and remaining burst length
   logic [APBUF_CNT_W-1:0] wr_q, wr_d, rd_q, rd_d, cnt_q, cnt_d;
   logic [APBUF_CNT_W-1:0] left_q, left_d;
   // Reply sequencer state
   apbuf_ustate_t st_q, st_d;
   // Request flag and drop pulse
   logic req_q, req_d, drop_q, drop_d;
   // Reply character, strobes and reply request bit
   logic [APBUF_CHAR_W-1:0] ch_q, ch_d;
   logic chv_q, chv_d, done_q, done_d, rhs_q, rhs_d;
   // Store handshake; pop is decided by the reply sequencer
   logic push, pop;

   // Wrap a pointer at the end of the array
   function automatic logic [APBUF_CNT_W-1:0] inc_ptr(
      input logic [APBUF_CNT_W-1:0] p);
      if (p == APBUF_CNT_W'(DEPTH - 1)) begin
         inc_ptr = '0;
      end else begin
         inc_ptr = p + 1'b1;
      end
   endfunction

   // One poll decode shared by both branches of the idle state
   function automatic logic poll_hit(input logic valid,
      input logic [1:0] kind_seen, input logic [1:0] kind_want);
      poll_hit = valid && (kind_seen == kind_want);
   endfunction

   // ==========================================================
   // Reply sequencer: takes a poll when idle, then pops one character
   // a cycle until the burst count or the buffer runs out
   // Polls that arrive while a reply runs are ignored, not queued
   always_comb begin
      st_d = st_q;
      left_d = left_q;
      chv_d = 1'b0;
      done_d = 1'b0;
      ch_d = ch_q;
      rhs_d = rhs_q;
      pop = 1'b0;
      case (st_q)
         APBUF_U_IDLE: begin
            if (poll_hit(link.poll_valid, link.poll, APBUF_POLL_LOW)) begin
               left_d = APBUF_CNT_W'(BURST); // RL1
               // Request level is frozen here for the whole reply
               rhs_d = req_q; // RL4 RL14
               st_d = APBUF_U_SEND;
            end else if (poll_hit(link.poll_valid, link.poll,
                                  APBUF_POLL_HIGH)) begin
               left_d = APBUF_CNT_W'(APBUF_HS_CHARS); // RL7
               // High replies never carry the request bit
               rhs_d = 1'b0; // RL4
               st_d = APBUF_U_SEND;
            end
         end
         APBUF_U_SEND: begin
            // An empty buffer still closes the reply so the poller moves on
            if (left_q == '0 || cnt_q == '0) begin
               done_d = 1'b1;
               st_d = APBUF_U_DONE;
            end else begin
               // Character word holds its value between strobes
               pop = 1'b1; // RL1 RL7
               ch_d = mem_q[rd_q];
               chv_d = 1'b1;
               left_d = left_q - 1'b1;
            end
         end
         APBUF_U_DONE: begin
            // One idle cycle lets the done pulse drop before a new poll
            st_d = APBUF_U_IDLE;
         end
         default: begin
            st_d = APBUF_U_IDLE;
         end
      endcase
   end

   // Reply registers; frozen with the rest while clk_en_i is low
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         st_q <= APBUF_U_IDLE;
         left_q <= '0;
         ch_q <= '0;
         chv_q <= 1'b0;
         done_q <= 1'b0;
         rhs_q <= 1'b0;
      end else if (clk_en_i) begin
         st_q <= st_d;
         left_q <= left_d;
         ch_q <= ch_d;
         chv_q <= chv_d;
         done_q <= done_d;
         rhs_q <= rhs_d;
      end
   end

   // ==========================================================
   // Character store pointers and fill count
   // Terminal never stalls; out of reset and with clk_en_i high, only a full buffer loses a character.
   // A pop in the same cycle does not make room for a push: one lost
   // character at the very top is traded for a simpler full compare.
   always_comb begin
      push = term_valid_i && (cnt_q != APBUF_CNT_W'(DEPTH)); // RL6
      drop_d = term_valid_i && !push;
      wr_d = push ? inc_ptr(wr_q) : wr_q;
      rd_d = pop ? inc_ptr(rd_q) : rd_q;
      cnt_d = cnt_q + APBUF_CNT_W'(push) - APBUF_CNT_W'(pop);
   end

   // Memory has no reset so it maps onto RAM
   always_ff @(posedge sys_clk_i) begin
      if (clk_en_i && push) begin
         mem_q[wr_q] <= term_char_i;
      end
   end

   // Pointer, count and drop registers
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         drop_q <= 1'b0;
      end else if (clk_en_i) begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         drop_q <= drop_d;
      end
   end

   // ==========================================================
   // High-speed request flag
   // A pure level compare on the next count, so a set and a clear can
   // never race; the bit follows the fill both ways.
   // Pops and pushes in one cycle are both seen before the compare.
   always_comb begin
      req_d = (cnt_d >= APBUF_CNT_W'(THRESH)); // RL2 RL3 RL5
   end

   // Request flag register
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         req_q <= 1'b0;
      end else if (clk_en_i) begin
         req_q <= req_d;
      end
   end

   // ==========================================================
   // Outputs, all straight from registers
   // The reply request bit stands until the next poll is taken, so the
   // poller may sample it together with the done pulse
   assign link.rsp_char = ch_q;
   assign link.rsp_char_valid = chv_q;
   assign link.rsp_done = done_q;
   assign link.rsp_hs_req = rhs_q;
   assign term_drop_o = drop_q;
   assign hs_req_o = req_q;
   assign fill_o = cnt_q;
endmodule

// File: design/apb_pkg.sv
// Package for the adaptive poll buffer: sizes, thresholds, poll codes.
// Assumes both ends of the poll link share one clock and one reset.
package apbuf_pkg;
   // ==========================================================
   // Buffer sizing
   localparam int APBUF_DEPTH = 192;
   localparam int APBUF_THRESH = 96;
   localparam int APBUF_LS_CHARS = 8;
   localparam int APBUF_CHAR_W = 7;
   localparam int APBUF_CNT_W = 8;
   // ==========================================================
   // Poll schedule of the controller
   localparam int APBUF_POLLS_PER_CYCLE = 32;
   localparam int APBUF_HS_CHARS = 8;
   // ==========================================================
   // Poll kinds on the link
   typedef enum logic [1:0] {
      APBUF_POLL_NONE = 2'b00,
      APBUF_POLL_LOW = 2'b01,
      APBUF_POLL_HIGH = 2'b10
   } apbuf_poll_t;
endpackage

// File: design/apb_link_if.sv
// Poll link between the channel controller and the subscriber buffer unit.
// Assumes a shared clock; no clocking block, the ends are plain logic.
`timescale 1ns/1ns
interface apbuf_link_if;
   import apbuf_pkg::*;
   logic [1:0] poll;
   logic poll_valid;
   logic [APBUF_CHAR_W-1:0] rsp_char;
   logic rsp_char_valid;
   logic rsp_done;
   logic rsp_hs_req;
   modport unit_mp (input poll, input poll_valid, output rsp_char,
      output rsp_char_valid, output rsp_done, output rsp_hs_req);
   modport ctrl_mp (output poll, output poll_valid, input rsp_char,
      input rsp_char_valid, input rsp_done, input rsp_hs_req);
endinterface

// File: design/apb_ctrl.sv
// Channel controller end: issues low- and high-speed polls to one unit.
// Assumes the unit answers each poll with rsp_done on the same clock.
`timescale 1ns/1ns
module apbuf_ctrl
   import apbuf_pkg::*;
#(
   parameter int POLLS = APBUF_POLLS_PER_CYCLE
) (
   // Clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic clk_en_i,
   // Poll pacing from the scheduler
   input wire logic slot_i,
   // Received characters and high-speed grant
   output logic [APBUF_CHAR_W-1:0] rx_char_o,
   output logic rx_valid_o,
   output logic hs_active_o,
   // Poll link
   apbuf_link_if.ctrl_mp link
);
   // ==========================================================
   // Poll sequencer: slot 0 of each cycle is the low-speed poll
   logic [5:0] slot_q, slot_d;
   logic busy_q, busy_d, hs_q, hs_d;
   logic [1:0] poll_q, poll_d;
   logic pv_q, pv_d;
   logic [APBUF_CHAR_W-1:0] rx_q, rx_d;
   logic rxv_q, rxv_d;

   always_comb begin
      slot_d = slot_q;
      busy_d = busy_q;
      hs_d = hs_q;
      poll_d = poll_q;
      pv_d = 1'b0;
      rxv_d = link.rsp_char_valid;
      rx_d = link.rsp_char_valid ? link.rsp_char : rx_q;
      if (busy_q && link.rsp_done) begin
         busy_d = 1'b0;
         if (poll_q == APBUF_POLL_LOW) begin
            hs_d = link.rsp_hs_req; // RL8
         end
      end
      if (slot_i && !busy_q) begin
         if (slot_q == '0) begin
            poll_d = APBUF_POLL_LOW; // RL11
            pv_d = 1'b1;
            busy_d = 1'b1;
         end else if (hs_q) begin
            poll_d = APBUF_POLL_HIGH; // RL12
            pv_d = 1'b1;
            busy_d = 1'b1;
         end
         slot_d = (slot_q == 6'(POLLS - 1)) ? '0 : slot_q + 1'b1; // RL13
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         slot_q <= '0;
         busy_q <= 1'b0;
         hs_q <= 1'b0;
         poll_q <= APBUF_POLL_NONE;
         pv_q <= 1'b0;
         rx_q <= '0;
         rxv_q <= 1'b0;
      end else if (clk_en_i) begin
         slot_q <= slot_d;
         busy_q <= busy_d;
         hs_q <= hs_d;
         poll_q <= poll_d;
         pv_q <= pv_d;
         rx_q <= rx_d;
         rxv_q <= rxv_d;
      end
   end

   assign link.poll = poll_q;
   assign link.poll_valid = pv_q;
   assign rx_char_o = rx_q;
   assign rx_valid_o = rxv_q;
   assign hs_active_o = hs_q;
endmodule

// File: test/apbuf_monitor.sv
// Checker for the poll link between controller and buffer unit.
// Assumes one clock; instantiated beside the link interface.
`timescale 1ns/1ns
module apbuf_monitor
   import apbuf_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // Link signals
   input wire logic [1:0] poll,
   input wire logic poll_valid,
   input wire logic [APBUF_CHAR_W-1:0] rsp_char,
   input wire logic rsp_char_valid,
   input wire logic rsp_done,
   input wire logic rsp_hs_req
);
   logic low_q, low_d, grant_q, grant_d;
   // ==========================================================
   // Grant tracking: last low reply decides high polling
   always_comb begin
      low_d = low_q;
      grant_d = grant_q;
      if (poll_valid)
         low_d = (poll == APBUF_POLL_LOW);
      if (rsp_done && low_q)
         grant_d = rsp_hs_req;
   end
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         low_q <= 1'h0;
         grant_q <= 1'h0;
      end else begin
         low_q <= low_d;
         grant_q <= grant_d;
      end
   end
   // ==========================================================
   // Link properties
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_start; ##2 (rsp_char_valid || rsp_done); endsequence
   sequence s_burst; rsp_char_valid [*8]; endsequence
   property p_start; poll_valid |-> s_start; endproperty
   property p_burst; s_burst |=> rsp_done; endproperty
   property p_end; $fell(rsp_char_valid) |-> rsp_done; endproperty
   property p_run; rsp_char_valid |=> rsp_char_valid || rsp_done; endproperty
   property p_req_low;
      $rose(rsp_hs_req) |-> $past(poll_valid) &&
         $past(poll) == APBUF_POLL_LOW;
   endproperty
   property p_req_high;
      poll_valid && poll == APBUF_POLL_HIGH |-> ##3 !rsp_hs_req;
   endproperty
   property p_stop;
      poll_valid && poll == APBUF_POLL_HIGH |-> grant_q;
   endproperty
   // Poll kept to one cycle; a reply never shorter than two
   property p_gap; poll_valid |=> !poll_valid [*2]; endproperty
   a_start: assert property (p_start)
      else $error("no reply after poll");
   a_burst: assert property (p_burst)
      else $error("reply longer than eight");
   a_end: assert property (p_end)
      else $error("reply not closed");
   a_run: assert property (p_run)
      else $error("gap in reply");
   a_req_low: assert property (p_req_low)
      else $error("request outside low reply");
   a_req_high: assert property (p_req_high)
      else $error("request in high reply");
   a_stop: assert property (p_stop)
      else $error("high poll without grant");
   a_gap: assert property (p_gap)
      else $error("polls too close");
endmodule

// File: test/test_adaptive_poll_buffer.sv
// Bench: unit and controller joined by the link, terminal and slots driven.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/1ns
module test_adaptive_poll_buffer
   import apbuf_pkg::*;
;
   logic sys_clk_i = 1'h0, nrst_i = 1'h0, term_valid_i = 1'h0;
   logic slot_i = 1'h0, drop_seen = 1'h0, clk_en_i = 1'h1;
   logic [APBUF_CHAR_W-1:0] term_char_i = 7'h00, wc = 7'h00, rx_char_o;
   logic term_drop_o, hs_req_o, rx_valid_o, hs_active_o;
   logic [7:0] fill_o;
   logic [6:0] tq[$];
   int miscompares = 0, n_checks = 0;
   apbuf_link_if link_inst ();
   // ==========================================================
   // Design ends and link checker
   apbuf_unit apbuf_unit_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
      .clk_en_i(clk_en_i), .term_char_i(term_char_i),
      .term_valid_i(term_valid_i), .term_drop_o(term_drop_o),
      .hs_req_o(hs_req_o), .fill_o(fill_o), .link(link_inst));
   // Four slots per low cycle keeps each pass short
   apbuf_ctrl #(.POLLS(4)) apbuf_ctrl_inst (.sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i), .clk_en_i(clk_en_i), .slot_i(slot_i),
      .rx_char_o(rx_char_o), .rx_valid_o(rx_valid_o),
      .hs_active_o(hs_active_o), .link(link_inst));
   apbuf_monitor apbuf_monitor_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
      .poll(link_inst.poll), .poll_valid(link_inst.poll_valid),
      .rsp_char(link_inst.rsp_char),
      .rsp_char_valid(link_inst.rsp_char_valid),
      .rsp_done(link_inst.rsp_done), .rsp_hs_req(link_inst.rsp_hs_req));
   always #50 sys_clk_i = ~sys_clk_i;
   // ==========================================================
   // Tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // Terminal characters back to back; two idle edges let flags settle
   task automatic put(input int n);
      repeat (n) begin
         @(negedge sys_clk_i);
         term_valid_i = 1'h1;
         term_char_i = wc;
         tq.push_back(wc);
         wc++;
      end
      @(negedge sys_clk_i);
      term_valid_i = 1'h0;
      @(negedge sys_clk_i);
   endtask
   // One slot; longest reply is well inside the wait
   task automatic slot(input int n);
      @(negedge sys_clk_i);
      slot_i = 1'h1;
      @(negedge sys_clk_i);
      slot_i = 1'h0;
      fork
         put(n);
         repeat (16) @(negedge sys_clk_i);
      join
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Received characters must come out in terminal order
   always @(negedge sys_clk_i) begin
      if (rx_valid_o === 1'h1)
         chk({1'h0, rx_char_o}, {1'h0, tq.pop_front()});
      if (term_drop_o === 1'h1)
         drop_seen = 1'h1;
   end
   // ==========================================================
   // Sequence; slot 0 of every four is the low poll
   initial begin
      repeat (16) @(negedge sys_clk_i);
      nrst_i = 1'h1;
      put(20);
      slot(0);
      chk(fill_o, 8'h0c);
      repeat (3) slot(0);
      chk(fill_o, 8'h0c);
      put(83);
      chk({7'h00, hs_req_o}, 8'h00);
      put(1);
      chk({7'h00, hs_req_o}, 8'h01);
      slot(4);
      chk(fill_o, 8'h5c);
      chk({7'h00, hs_active_o}, 8'h01);
      chk({7'h00, hs_req_o}, 8'h00);
      repeat (3) slot(0);
      chk(fill_o, 8'h44);
      slot(0);
      chk({7'h00, hs_active_o}, 8'h00);
      slot(0);
      chk(fill_o, 8'h3c);
      // Frozen ends take no character however long the strobe stands
      @(negedge sys_clk_i);
      clk_en_i = 1'h0;
      term_valid_i = 1'h1;
      term_char_i = wc;
      repeat (3) @(negedge sys_clk_i);
      clk_en_i = 1'h1;
      term_valid_i = 1'h0;
      @(negedge sys_clk_i);
      chk(fill_o, 8'h3c);
      chk({7'h00, drop_seen}, 8'h00);
      put(132);
      chk(fill_o, 8'hc0);
      put(1);
      chk({7'h00, drop_seen}, 8'h01);
      chk(fill_o, 8'hc0);
      test_done();
   end
   // Watchdog: the sequence needs under a thousand cycles
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      miscompares++;
      test_done();
   end
endmodule
